// [verilog/sstr_pkg.sv]
/*
 Shared constants for the snapshot/trigger readout pair: sensor register
 map, field positions, reset values, frame geometry, controller register
 map and timing counts.
 Assumes a single 40 MHz clock shared by both ends.
*/
`default_nettype none
package sstr_pkg;
  localparam int CLK_PERIOD_NS = 25;

  // Sensor register offsets
  localparam logic [7:0] REG_RESTART      = 8'h0B;
  localparam logic [7:0] REG_READOUT_MODE = 8'h1E;
  localparam logic [7:0] REG_READ_OPTIONS = 8'h20;
  localparam logic [7:0] REG_CHIP_ENABLE  = 8'hF1;

  // Sensor field positions
  localparam int BIT_RESTART   = 0;
  localparam int BIT_SNAPSHOT  = 8;
  localparam int BIT_RV_FMT_LO = 9;
  localparam int BIT_RV_FMT_HI = 10;
  localparam int BIT_CHIP_EN   = 0;

  // Sensor reset values
  localparam logic        RST_SNAPSHOT = 1'b0;
  localparam logic [1:0]  RST_RV_FMT   = 2'h0;
  localparam logic        RST_CHIP_EN  = 1'b1;

  // Row-valid formats; 2'h3 behaves as the xor format
  localparam logic [1:0] RV_NORMAL = 2'h0;
  localparam logic [1:0] RV_CONT   = 2'h1;

  // Frame geometry in pixel-clock steps
  localparam int COL_W = 4;
  localparam int ROW_W = 3;
  localparam logic [COL_W-1:0] ACT_COLS = 4'h8;
  localparam logic [COL_W-1:0] COL_LAST = 4'hB;
  localparam logic [ROW_W-1:0] ACT_ROWS = 3'h4;
  localparam logic [ROW_W-1:0] ROW_LAST = 3'h5;

  // Controller APB map
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CMD    = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_COUNT  = 12'h00C;
  localparam int CTRL_SNAP    = 0;
  localparam int CTRL_FMT_LO  = 1;
  localparam int CTRL_FMT_HI  = 2;
  localparam int CTRL_CHIP_EN = 3;
  localparam int CTRL_STBY    = 4;
  localparam int CMD_TRIG     = 0;
  localparam int CMD_RESTART  = 1;
  localparam int CMD_APPLY    = 2;
  localparam logic [4:0] RST_CTRL = 5'h08;

  // Timing
  localparam int TRIG_PULSE_NS = 100;
  localparam logic [2:0] TRIG_CYCLES =
    3'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STBY_HOLD_CYC = 2'h2;

  typedef enum logic [2:0] {
    DS_OFF  = 3'h1,
    DS_WAIT = 3'h2,
    DS_READ = 3'h4
  } sstr_dst_e;

  typedef enum logic [1:0] {
    CS_IDLE = 2'h1,
    CS_ACK  = 2'h2
  } sstr_cst_e;
endpackage : sstr_pkg
`default_nettype wire

// [verilog/sstr_if.sv]
/*
 Link between the sensor readout end and the capture controller end:
 trigger, standby, register port and frame/row qualifiers with pixels.
 Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sstr_if;
  logic        trigger;
  logic        standby;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        frame_valid;
  logic        row_valid;
  logic        pixel_clock_out;
  logic [9:0]  pixel_data;

  modport sensor (
    input  trigger, standby, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_ack, frame_valid, row_valid,
    output pixel_clock_out, pixel_data
  );
  modport ctrl (
    output trigger, standby, reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_ack, frame_valid, row_valid,
    input  pixel_clock_out, pixel_data
  );
endinterface : sstr_if
`default_nettype wire

// [verilog/sstr_sensor.sv]
/*
 Sensor end: register port, continuous and snapshot readout sequencing,
 row-valid formatting, chip-enable stop/restart and standby hold.
 Assumes the controller end drives trigger, standby and the register port
 synchronously to pclk, one register access at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module sstr_sensor (
  input  wire logic  pclk,
  input  wire logic  presetn,
  sstr_if.sensor     lnk,
  output var  logic  sensor_busy
);
  import sstr_pkg::*;

  typedef struct packed {
    sstr_dst_e        st;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic             pck;
    logic             trig_prev;
    logic             snap;
    logic [1:0]       rv_fmt;
    logic             chip_en;
    logic             fv;
    logic             rv;
    logic [9:0]       data;
    logic [15:0]      rdata;
    logic             ack;
    logic             busy;
  } sstr_dev_s;

  sstr_dev_s q;
  sstr_dev_s d;
  logic      trig_rise;
  logic      restart;
  logic      act_row;
  logic      act_col;

  function automatic logic rv_format(
    input logic [1:0] fmt,
    input logic       cont_rv,
    input logic       fv
  );
    logic r;
    case (fmt)
      RV_NORMAL: r = cont_rv & fv;
      RV_CONT:   r = cont_rv;
      default:   r = cont_rv ^ fv;
    endcase
    return r;
  endfunction : rv_format

  function automatic logic [15:0] reg_value(
    input logic [7:0] addr,
    input sstr_dev_s  s
  );
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      REG_READOUT_MODE: v[BIT_SNAPSHOT] = s.snap;
      REG_READ_OPTIONS: v[BIT_RV_FMT_HI:BIT_RV_FMT_LO] = s.rv_fmt;
      REG_CHIP_ENABLE:  v[BIT_CHIP_EN] = s.chip_en;
      default:          v = 16'h0000;
    endcase
    return v;
  endfunction : reg_value

  always_comb begin
    d = q;
    d.ack = 1'b0;
    restart = 1'b0;
    d.trig_prev = lnk.trigger;
    // Edge, not level: a held trigger gives one frame only
    trig_rise = lnk.trigger & ~q.trig_prev;
    act_row = q.row < ACT_ROWS;
    act_col = q.col < ACT_COLS;

    if (lnk.reg_wr) begin
      d.ack = 1'b1;
      case (lnk.reg_addr)
        REG_READOUT_MODE: d.snap = lnk.reg_wdata[BIT_SNAPSHOT];
        REG_READ_OPTIONS: begin
          d.rv_fmt = lnk.reg_wdata[BIT_RV_FMT_HI:BIT_RV_FMT_LO];
        end
        REG_CHIP_ENABLE:  d.chip_en = lnk.reg_wdata[BIT_CHIP_EN];
        // Restart bit is self clearing, so it reads back as zero
        REG_RESTART:      restart = lnk.reg_wdata[BIT_RESTART];
        default:          d.ack = 1'b1;
      endcase
    end
    if (lnk.reg_rd) begin
      d.ack = 1'b1;
      d.rdata = reg_value(lnk.reg_addr, q);
    end

    if (lnk.standby) begin
      // Clock may stop three cycles later; park everything quietly
      d.st = DS_OFF;
      d.col = '0;
      d.row = '0;
      d.fv = 1'b0;
      d.rv = 1'b0;
      d.data = 10'h000;
    end else if (~d.chip_en) begin
      d.pck = ~q.pck;
      d.st = DS_OFF;
      d.col = '0;
      d.row = '0;
      d.fv = 1'b0;
      d.rv = 1'b0;
      d.data = 10'h000;
    end else begin
      d.pck = ~q.pck;
      case (q.st)
        DS_OFF: begin
          // Counters are already at the first row of a fresh frame
          d.st = d.snap ? DS_WAIT : DS_READ;
        end
        DS_WAIT: begin
          d.fv = 1'b0;
          d.rv = 1'b0;
          d.data = 10'h000;
          if (~d.snap) begin
            d.st = DS_READ;
          end else if (trig_rise | restart) begin
            d.st = DS_READ;
          end
        end
        DS_READ: begin
          if (restart & ~q.snap) begin
            d.col = '0;
            d.row = '0;
          end else if (q.pck) begin
            // Same geometry in both modes; only the end differs
            d.fv = act_row;
            d.rv = rv_format(q.rv_fmt, act_col, act_row);
            d.data = (act_row & act_col) ? {3'h0, q.row, q.col} : 10'h000;
            if (q.col == COL_LAST) begin
              d.col = '0;
              if (q.row == ROW_LAST) begin
                d.row = '0;
                if (d.snap) begin
                  d.st = DS_WAIT;
                end
              end else begin
                d.row = q.row + 1'b1;
              end
            end else begin
              d.col = q.col + 1'b1;
            end
          end
          // Triggers during readout are dropped, not queued
        end
        default: d.st = DS_OFF;
      endcase
    end
    d.busy = (d.st == DS_READ);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= DS_OFF;
      q.col <= '0;
      q.row <= '0;
      q.pck <= 1'b0;
      q.trig_prev <= 1'b0;
      q.snap <= RST_SNAPSHOT;
      q.rv_fmt <= RST_RV_FMT;
      q.chip_en <= RST_CHIP_EN;
      q.fv <= 1'b0;
      q.rv <= 1'b0;
      q.data <= 10'h000;
      q.rdata <= 16'h0000;
      q.ack <= 1'b0;
      q.busy <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign lnk.frame_valid = q.fv;
  assign lnk.row_valid = q.rv;
  assign lnk.pixel_clock_out = q.pck;
  assign lnk.pixel_data = q.data;
  assign lnk.reg_rdata = q.rdata;
  assign lnk.reg_ack = q.ack;
  assign sensor_busy = q.busy;
endmodule : sstr_sensor
`default_nettype wire

// [verilog/sstr_ctrl.sv]
/*
 Capture controller end: APB slave with control, command, status and
 count registers; sensor register writer; trigger pulser; standby
 sequencing with master-clock run output; frame and pixel counting.
 Assumes an APB master on pclk and the sensor end on the interface.
*/
`timescale 1ns/1ps
`default_nettype none
module sstr_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        mclk_run,
  sstr_if.ctrl             lnk
);
  import sstr_pkg::*;

  typedef struct packed {
    sstr_cst_e   st;
    logic [3:0]  pend;
    logic [1:0]  idx;
    logic [4:0]  ctrl;
    logic [2:0]  trig_cnt;
    logic        trig;
    logic        stby;
    logic [1:0]  stby_cnt;
    logic        run;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        pck_prev;
    logic        fv_prev;
    logic [15:0] frames;
    logic [15:0] pix;
    logic [15:0] last_pix;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sstr_ctl_s;

  sstr_ctl_s q;
  sstr_ctl_s d;
  logic      setup;
  logic      access;
  logic      mapped;
  logic      sample;
  logic [3:0] pend_new;
  logic [1:0] sel;

  function automatic logic [23:0] sensor_word(
    input logic [1:0] idx,
    input logic [4:0] c
  );
    logic [15:0] w;
    logic [7:0]  a;
    w = 16'h0000;
    case (idx)
      2'h0: begin
        a = REG_READOUT_MODE;
        w[BIT_SNAPSHOT] = c[CTRL_SNAP];
      end
      2'h1: begin
        a = REG_READ_OPTIONS;
        w[BIT_RV_FMT_HI:BIT_RV_FMT_LO] = c[CTRL_FMT_HI:CTRL_FMT_LO];
      end
      2'h2: begin
        a = REG_CHIP_ENABLE;
        w[BIT_CHIP_EN] = c[CTRL_CHIP_EN];
      end
      default: begin
        a = REG_RESTART;
        w[BIT_RESTART] = 1'b1;
      end
    endcase
    return {a, w};
  endfunction : sensor_word

  always_comb begin
    d = q;
    setup = psel & ~penable;
    access = psel & penable & q.pready;
    mapped = (paddr == OFS_CTRL) | (paddr == OFS_CMD) |
             (paddr == OFS_STATUS) | (paddr == OFS_COUNT);
    pend_new = 4'h0;
    sel = 2'h0;

    // No wait state; read data is registered in the setup cycle so it comes from a flop
    d.pready = setup;
    d.pslverr = setup & ~mapped;
    if (setup) begin
      case (paddr)
        OFS_CTRL:   d.prdata = {27'h0, q.ctrl};
        OFS_STATUS: d.prdata = {26'h0, lnk.frame_valid, ~q.run, q.stby,
                                q.trig, (q.st != CS_IDLE), (q.pend != 4'h0)};
        OFS_COUNT:  d.prdata = {q.last_pix, q.frames};
        default:    d.prdata = 32'h0000_0000;
      endcase
    end
    if (access & pwrite & mapped) begin
      if (paddr == OFS_CTRL) begin
        d.ctrl = pwdata[4:0];
        pend_new[2:0] = 3'h7;
      end
      if (paddr == OFS_CMD) begin
        if (pwdata[CMD_APPLY]) pend_new[2:0] = 3'h7;
        if (pwdata[CMD_RESTART]) pend_new[3] = 1'b1;
        // Pin trigger only in snapshot mode and when idle
        if (pwdata[CMD_TRIG] & q.ctrl[CTRL_SNAP] & ~q.trig) begin
          d.trig_cnt = TRIG_CYCLES;
        end
      end
    end

    // Trigger pulse; forced low outside snapshot mode
    if (q.trig_cnt != 3'h0) d.trig_cnt = q.trig_cnt - 1'b1;
    d.trig = (q.trig_cnt != 3'h0) & d.ctrl[CTRL_SNAP];

    // Standby entry: assert standby, two more clocks, then stop
    if (d.ctrl[CTRL_STBY]) begin
      d.stby = 1'b1;
      if (q.stby & (q.stby_cnt != STBY_HOLD_CYC)) d.stby_cnt = q.stby_cnt + 1'b1;
      d.run = ~(q.stby & (q.stby_cnt == STBY_HOLD_CYC));
    end else begin
      d.run = 1'b1;
      d.stby_cnt = 2'h0;
      d.stby = ~q.run;   // Leave standby only once clock runs again
    end

    // Sensor register writer, one write in flight
    d.wr = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (q.pend[i]) sel = 2'(i);
    end
    case (q.st)
      CS_IDLE: begin
        if ((q.pend != 4'h0) & q.run & ~q.stby) begin
          d.idx = sel;
          {d.addr, d.wdata} = sensor_word(sel, q.ctrl);
          d.wr = 1'b1;
          d.st = CS_ACK;
        end
      end
      CS_ACK: begin
        if (lnk.reg_ack) d.st = CS_IDLE;
      end
      default: d.st = CS_IDLE;
    endcase
    // A new request beats the completion clearing the same bit
    d.pend = (q.pend & ~(((q.st == CS_ACK) & lnk.reg_ack) ?
              4'(1 << q.idx) : 4'h0)) | pend_new;

    // Pixel and frame counting on pixel clock rise
    d.pck_prev = lnk.pixel_clock_out;
    sample = lnk.pixel_clock_out & ~q.pck_prev;
    if (sample) begin
      d.fv_prev = lnk.frame_valid;
      if (lnk.frame_valid & lnk.row_valid) d.pix = q.pix + 1'b1;
      if (q.fv_prev & ~lnk.frame_valid) begin
        d.frames = q.frames + 1'b1;
        d.last_pix = q.pix;
        d.pix = 16'h0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= CS_IDLE;
      q.pend <= 4'h0;
      q.idx <= 2'h0;
      q.ctrl <= RST_CTRL;
      q.trig_cnt <= 3'h0;
      q.trig <= 1'b0;
      q.stby <= 1'b0;
      q.stby_cnt <= 2'h0;
      q.run <= 1'b1;
      q.wr <= 1'b0;
      q.addr <= 8'h00;
      q.wdata <= 16'h0000;
      q.pck_prev <= 1'b0;
      q.fv_prev <= 1'b0;
      q.frames <= 16'h0000;
      q.pix <= 16'h0000;
      q.last_pix <= 16'h0000;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mclk_run = q.run;
  assign lnk.trigger = q.trig;
  assign lnk.standby = q.stby;
  assign lnk.reg_wr = q.wr;
  assign lnk.reg_rd = 1'b0;
  assign lnk.reg_addr = q.addr;
  assign lnk.reg_wdata = q.wdata;
endmodule : sstr_ctrl
`default_nettype wire

// [testbench/sstr_chk.sv]
/*
 Checker for the link between the sensor end and the controller end.
 Assumes tb instantiates it beside the link, all on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sstr_chk (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       trigger,
  input  wire logic       standby,
  input  wire logic       reg_wr,
  input  wire logic       reg_ack,
  input  wire logic       frame_valid,
  input  wire logic       row_valid,
  input  wire logic       pixel_clock_out,
  input  wire logic [9:0] pixel_data,
  input  wire logic       mclk_run
);
  logic [7:0] fv_run_q;
  logic [7:0] fv_run_d;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Run length of frame_valid; a stuck qualifier shows up as an overlong run
  always_comb begin
    fv_run_d = frame_valid ? fv_run_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fv_run_q <= 8'h00;
    end else begin
      fv_run_q <= fv_run_d;
    end
  end

  sequence s_trig_pulse;
    trigger [*4] ##1 !trigger;
  endsequence
  sequence s_clock_stop;
    mclk_run [*3] ##1 !mclk_run;
  endsequence

  a_ack_follows_wr: assert property (reg_wr |=> reg_ack && !reg_wr)
    else $error("register write not acknowledged next cycle");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr))
    else $error("acknowledge without a write");
  a_trig_width: assert property ($rose(trigger) |-> s_trig_pulse)
    else $error("trigger pulse width wrong");
  a_stby_clock_hold: assert property ($rose(standby) |-> s_clock_stop)
    else $error("clock stopped too early after standby");
  a_clock_needs_stby: assert property (!mclk_run |-> standby)
    else $error("clock stopped without standby");
  a_stby_leave: assert property ($fell(standby) |-> $past(mclk_run))
    else $error("standby left before clock restarted");
  a_stby_quiet: assert property (standby [*3] |-> !frame_valid && !row_valid)
    else $error("qualifiers active in standby");
  a_pclk_runs: assert property (
    !standby [*4] |-> pixel_clock_out != $past(pixel_clock_out))
    else $error("pixel clock not toggling");
  a_idle_data_zero: assert property (!frame_valid |-> pixel_data == 10'h000)
    else $error("pixel data outside frame");
  a_frame_length: assert property (fv_run_q <= 8'h60)
    else $error("frame valid run too long");
endmodule : sstr_chk
`default_nettype wire

// [testbench/tb.sv]
/*
 Self-checking bench: APB master for the controller, a watcher on the
 link, tests for row-valid formats, chip enable, snapshot, restart, standby.
 Assumes the package, the link interface and both ends compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module tb;
  import sstr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mclk_run;
  logic        sensor_busy;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          checks_done;
  int          n_fv, n_rv, n_rvfv, n_rise, n_tog, n_busy, n_first, n_trig;
  int          exp_rv[4]   = '{64, 96, 64, 64};
  int          exp_rvfv[4] = '{64, 64, 32, 32};

  sstr_if u_lnk ();
  sstr_sensor u_sstr_sensor (.pclk(pclk), .presetn(presetn), .lnk(u_lnk.sensor),
    .sensor_busy(sensor_busy));
  sstr_ctrl u_sstr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mclk_run(mclk_run), .lnk(u_lnk.ctrl));
  sstr_chk chk (.pclk(pclk), .presetn(presetn), .trigger(u_lnk.trigger),
    .standby(u_lnk.standby), .reg_wr(u_lnk.reg_wr), .reg_ack(u_lnk.reg_ack),
    .frame_valid(u_lnk.frame_valid), .row_valid(u_lnk.row_valid),
    .pixel_clock_out(u_lnk.pixel_clock_out), .pixel_data(u_lnk.pixel_data),
    .mclk_run(mclk_run));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic test_done();
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts qualifier activity at falling edges, where everything has settled
  task automatic watch(input int n);
    logic pf;
    logic pc;
    logic fell;
    {n_fv, n_rv, n_rvfv, n_rise, n_tog, n_busy, n_first, n_trig} = '0;
    pf = u_lnk.frame_valid;
    pc = u_lnk.pixel_clock_out;
    fell = 1'b0;
    repeat (n) begin
      @(negedge pclk);
      if (u_lnk.frame_valid === 1'b1) n_fv++;
      if (u_lnk.row_valid === 1'b1) n_rv++;
      if (u_lnk.row_valid === 1'b1 && u_lnk.frame_valid === 1'b1) n_rvfv++;
      if (u_lnk.frame_valid === 1'b1 && pf !== 1'b1) n_rise++;
      if (u_lnk.frame_valid !== 1'b1 && pf === 1'b1) fell = 1'b1;
      if (u_lnk.frame_valid === 1'b1 && !fell) n_first++;
      if (u_lnk.pixel_clock_out !== pc) n_tog++;
      if (sensor_busy === 1'b1) n_busy++;
      if (u_lnk.trigger === 1'b1) n_trig++;
      pf = u_lnk.frame_valid;
      pc = u_lnk.pixel_clock_out;
    end
  endtask : watch

  // Stops at the falling edge where a new frame has just begun
  task automatic sync();
    int  i;
    logic p;
    p = u_lnk.frame_valid;
    for (i = 0; i < 300; i++) begin
      @(negedge pclk);
      if (u_lnk.frame_valid === 1'b1 && p !== 1'b1) break;
      p = u_lnk.frame_valid;
    end
    `CHK("frame start", 1'b1, i < 300)
  endtask : sync

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000008, rd)
    apb(1'b1, 12'h010, 32'h0000001F);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl kept", 32'h00000008, rd)
    // One whole frame period per format, after the new setting has landed
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, OFS_CTRL, 32'(8 + 2 * f));
      sync();
      sync();
      watch(144);
      `CHK("fv steps", 96, n_fv)
      `CHK("rv steps", exp_rv[f], n_rv)
      `CHK("rv in frame", exp_rvfv[f], n_rvfv)
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    watch(200);
    watch(300);
    `CHK("fv disabled", 0, n_fv)
    apb(1'b1, OFS_CTRL, 32'h8);
    watch(300);
    `CHK("first frame", 96, n_first)
    apb(1'b1, OFS_CTRL, 32'h9);
    watch(300);
    watch(300);
    `CHK("fv waiting", 0, n_fv)
    `CHK("pclk waiting", 300, n_tog)
    `CHK("busy waiting", 0, n_busy)
    // Second trigger lands while the frame is still being read
    fork
      watch(450);
      begin
        apb(1'b1, OFS_CMD, 32'h1);
        repeat (20) @(posedge pclk);
        apb(1'b1, OFS_CMD, 32'h1);
      end
    join
    `CHK("frames per trigger", 1, n_rise)
    `CHK("busy in frame", 1'b1, n_busy > 0 && n_busy <= 144)
    `CHK("snapshot frame", 96, n_first)
    apb(1'b0, OFS_COUNT, 32'h0);
    `CHK("pixels in frame", 16'h0020, rd[31:16])
    fork
      watch(300);
      apb(1'b1, OFS_CMD, 32'h2);
    join
    `CHK("restart frame", 1, n_rise)
    apb(1'b1, OFS_CTRL, 32'h18);
    watch(100);
    `CHK("clock stopped", 1'b0, mclk_run)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status standby", 2'b11, rd[4:3])
    apb(1'b1, OFS_CTRL, 32'h8);
    fork
      watch(400);
      apb(1'b1, OFS_CMD, 32'h1);
    join
    `CHK("clock back", 1'b1, mclk_run)
    `CHK("trigger in video", 0, n_trig)
    `CHK("video resumes", 1'b1, n_rise > 0)
    test_done();
  end
endmodule : tb
`default_nettype wire
